// ### shared/dsag_regs.svh
/*
  register offsets, field positions, reset values and timing counts of the
  channel sync and address generation block.
  assumes a plain strobe register port with byte offsets, one word each.
*/
`ifndef DSAG_REGS_SVH
`define DSAG_REGS_SVH

// ============================================================
// register offsets
`define DSAG_OFF_PRIMARY   8'h00
`define DSAG_OFF_SECOND    8'h04
`define DSAG_OFF_STEP0     8'h08
`define DSAG_OFF_STEP1     8'h0c
`define DSAG_OFF_SRC       8'h10
`define DSAG_OFF_DST       8'h14
`define DSAG_OFF_STATUS    8'h18

// ============================================================
// primary control fields
`define DSAG_PRI_SRCSEL_LO 0
`define DSAG_PRI_DSTSEL_LO 2
`define DSAG_PRI_WIDTH_LO  4
`define DSAG_PRI_FRAME     6
`define DSAG_PRI_INDEX     7
`define DSAG_PRI_BIGEND    8
`define DSAG_PRI_RSEL_LO   9
`define DSAG_PRI_WSEL_LO   14

// secondary control fields
`define DSAG_SEC_WPOL      0
`define DSAG_SEC_RPOL      1
`define DSAG_SEC_FRAME_SYNC_IGNORE      2

// ============================================================
// reset values and constants
`define DSAG_RST_WORD      32'h0000_0000
`define DSAG_SEL_NONE      5'h00
`define DSAG_STEP_KEEP     2'h0
`define DSAG_STEP_INC      2'h1
`define DSAG_STEP_DEC      2'h2
`define DSAG_STEP_IDX      2'h3
`define DSAG_W_BYTE        2'h0
`define DSAG_W_HALF        2'h1
`define DSAG_W_WORD        2'h2

// ============================================================
// timing: re-arm wait after a frame burst, in core clocks
`define DSAG_REARM_CYCLES  6'h20
`define DSAG_REARM_CNT_W   6

`endif

// ### shared/dsag_pkg.sv
/*
  types of the channel sync and address generation block.
  assumes dsag_regs.svh supplies the numbers.
*/
package dsag_pkg;

  // ============================================================
  // primary control word
  typedef struct packed {
    logic [12:0] unused;              // read as zero, keeps the word at 32 bits
    logic [4:0]  write_event_select;  // write event, zero means none
    logic [4:0]  read_event_select;   // read or frame event
    logic        big_endian;          // byte lane order
    logic        index_select;        // which global step register
    logic        frame_sync;          // frame synchronised mode
    logic [1:0]  element_width;       // byte, half, word
    logic [1:0]  dest_step_select;    // dest step mode
    logic [1:0]  source_step_select;  // source step mode
  } dsag_primary_t;

  // transfer request from the engine
  typedef struct packed {
    logic is_write;     // write transfer when high, read otherwise
    logic last_in_frame;// last element of its frame
    logic prog_mem;     // access goes to program memory
  } dsag_xfer_t;

  // sync state machine
  typedef enum logic [2:0] {
    DSAG_IDLE  = 3'b001,  // waiting for an event
    DSAG_BURST = 3'b010,  // frame burst running
    DSAG_WAIT  = 3'b100   // post burst delay
  } dsag_state_t;

endpackage

// ### rtl/dsag_event_det.sv
/*
  one synchronisation event detector: pin sync, polarity, edge latch.
  assumes the pin is asynchronous and clear pulses come from core_clk logic.
*/
`timescale 1ns/1ps
`include "dsag_regs.svh"
module dsag_event_det import dsag_pkg::*; (
  input  wire logic core_clk,   // core clock
  input  wire logic rst,        // sync reset, high
  input  wire logic pin,        // raw event pin
  input  wire logic invert,     // active low when set
  input  wire logic gate,       // block latching when high
  input  wire logic level_arm,  // latch by level this cycle
  input  wire logic clr,        // consume the pending event
  output logic      active,     // event at its active level
  output logic      pending     // latched event
);
  logic sync1_q;   // first synchroniser stage
  logic sync2_q;   // second synchroniser stage
  logic prev_q;    // previous active level
  logic hit;       // event seen this cycle

  // ============================================================
  // two flop synchroniser
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
    end
  end

  assign active = sync2_q ^ invert;

  // edge history of the active level
  always_ff @(posedge core_clk) begin
    if (rst) prev_q <= 1'b0;
    else     prev_q <= active;
  end

  assign hit = !gate && ((active && !prev_q) || (level_arm && active));

  // latch wins over a simultaneous clear
  always_ff @(posedge core_clk) begin
    if (rst)      pending <= 1'b0;
    else if (hit) pending <= 1'b1;
    else if (clr) pending <= 1'b0;
  end
endmodule // dsag_event_det

// ### rtl/dsag_channel.sv
/*
  one channel: event recognition with polarity, burst gating and re-arm,
  plus source and destination address generation and byte lane selection.
  assumes a transfer engine pulses xfer_done per performed transfer and
  a frame done pulse at the end of each frame burst.
*/
`timescale 1ns/1ps
`include "dsag_regs.svh"
module dsag_channel import dsag_pkg::*; (
  input  wire logic        core_clk,      // core clock, 40 MHz
  input  wire logic        rst,           // sync reset, high
  input  wire logic [7:0]  reg_addr,      // register byte address
  input  wire logic [31:0] reg_wdata,     // register write data
  input  wire logic        reg_wr,        // write strobe
  input  wire logic        reg_rd,        // read strobe
  output logic      [31:0] reg_rdata,     // read data, cycle after strobe
  input  wire logic        read_event_pin,  // read or frame event pin
  input  wire logic        write_event_pin, // write event pin
  input  wire logic        xfer_done,     // one transfer performed
  input  wire dsag_xfer_t  xfer,          // kind of that transfer
  input  wire logic        frame_done,    // frame burst finished
  output logic             read_go,       // read may proceed
  output logic             write_go,      // write may proceed
  output logic      [31:0] src_addr,      // current source address
  output logic      [31:0] dst_addr,      // current dest address
  output logic      [3:0]  lane_en,       // byte lanes of next access
  output logic      [1:0]  access_width   // width of next access
);
  dsag_primary_t pri_q;          // primary control
  logic [2:0]    sec_q;          // polarity and frame ignore
  logic [31:0]   step0_q;        // global step values, set 0
  logic [31:0]   step1_q;        // global step values, set 1
  logic [31:0]   src_q;          // source address
  logic [31:0]   dst_q;          // dest address
  dsag_state_t   state_q;        // sync state
  logic [`DSAG_REARM_CNT_W-1:0] wait_q; // post burst counter
  logic          rd_active;      // read event at active level
  logic          wr_active;      // write event at active level
  logic          rd_pend;        // read or frame event latched
  logic          wr_pend;        // write event latched
  logic          frame_sync_ignore_on;        // frame ignore in effect
  logic          gate_rd;        // gating for read detector
  logic          arm_rd;         // level arm pulse
  logic          clr_rd;         // consume read event
  logic          clr_wr;         // consume write event
  logic          frame_start;    // first read of a frame
  logic          rd_need;        // read sync selected
  logic          wr_need;        // write sync selected
  logic [31:0]   gstep;          // selected global step word
  logic [1:0]    eff_width;      // width after program memory rule
  logic [31:0]   src_next;       // next source address
  logic [31:0]   dst_next;       // next dest address
  logic [31:0]   rd_mux;         // read data mux

  // ============================================================
  // register writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pri_q   <= dsag_primary_t'(`DSAG_RST_WORD);
      sec_q   <= 3'h0;
      step0_q <= `DSAG_RST_WORD;
      step1_q <= `DSAG_RST_WORD;
    end else if (reg_wr) begin
      case (reg_addr)
        `DSAG_OFF_PRIMARY: pri_q   <= dsag_primary_t'({13'h0, reg_wdata[18:0]});
        `DSAG_OFF_SECOND:  sec_q   <= reg_wdata[2:0];
        `DSAG_OFF_STEP0:   step0_q <= reg_wdata;
        `DSAG_OFF_STEP1:   step1_q <= reg_wdata;
        default: ;                                    // unmapped: ignored
      endcase
    end
  end

  // ============================================================
  // event detectors
  assign frame_sync_ignore_on = sec_q[`DSAG_SEC_FRAME_SYNC_IGNORE] && pri_q.frame_sync;
  // gated through the burst and the delay; the last wait cycle lets the level arm through
  assign gate_rd = frame_sync_ignore_on && (state_q == DSAG_BURST ||
                               (state_q == DSAG_WAIT && wait_q != '0));
  assign arm_rd  = frame_sync_ignore_on && (state_q == DSAG_WAIT) && (wait_q == '0);

  dsag_event_det u_rd_det (
    .core_clk  (core_clk),
    .rst       (rst),
    .pin       (read_event_pin),
    .invert    (sec_q[`DSAG_SEC_RPOL]),
    .gate      (gate_rd),
    .level_arm (arm_rd),
    .clr       (clr_rd),
    .active    (rd_active),
    .pending   (rd_pend)
  );

  dsag_event_det u_wr_det (
    .core_clk  (core_clk),
    .rst       (rst),
    .pin       (write_event_pin),
    .invert    (sec_q[`DSAG_SEC_WPOL]),
    .gate      (1'b0),
    .level_arm (1'b0),
    .clr       (clr_wr),
    .active    (wr_active),
    .pending   (wr_pend)
  );

  // ============================================================
  // go signals and automatic clearing
  assign rd_need = pri_q.read_event_select != `DSAG_SEL_NONE;
  assign wr_need = pri_q.write_event_select != `DSAG_SEL_NONE && !pri_q.frame_sync;
  assign frame_start = (state_q == DSAG_IDLE);
  // inside a frame burst the reads run free; the post burst wait needs a new event
  assign read_go  = !rd_need || rd_pend ||
                    (pri_q.frame_sync && state_q == DSAG_BURST);
  assign write_go = !wr_need || wr_pend;
  assign clr_rd = xfer_done && !xfer.is_write && rd_need &&
                  (!pri_q.frame_sync || frame_start);
  assign clr_wr = xfer_done && xfer.is_write && wr_need;

  // ============================================================
  // frame burst tracking and re-arm delay
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= DSAG_IDLE;
      wait_q  <= '0;
    end else begin
      case (state_q)
        DSAG_IDLE: begin
          if (pri_q.frame_sync && clr_rd) state_q <= DSAG_BURST;
        end
        DSAG_BURST: begin
          if (frame_done) begin
            state_q <= frame_sync_ignore_on ? DSAG_WAIT : DSAG_IDLE;
            wait_q  <= `DSAG_REARM_CYCLES - 6'h1;
          end
        end
        DSAG_WAIT: begin
          if (wait_q == '0) state_q <= DSAG_IDLE;
          else              wait_q  <= wait_q - 6'h1;
        end
        default: state_q <= DSAG_IDLE;
      endcase
    end
  end

  // ============================================================
  // address generation
  assign gstep = pri_q.index_select ? step1_q : step0_q;
  assign eff_width = xfer.prog_mem ? `DSAG_W_WORD : pri_q.element_width;

  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] sel,
                                            input logic [1:0] w, input logic [31:0] g,
                                            input logic last);
    logic [31:0] sz;
    logic [15:0] idx;
    sz  = (w == `DSAG_W_WORD) ? 32'h4 : ((w == `DSAG_W_HALF) ? 32'h2 : 32'h1);
    idx = last ? g[31:16] : g[15:0];
    case (sel)
      `DSAG_STEP_INC: step_addr = a + sz;
      `DSAG_STEP_DEC: step_addr = a - sz;
      `DSAG_STEP_IDX: step_addr = a + {{16{idx[15]}}, idx};
      default:        step_addr = a;
    endcase
  endfunction

  assign src_next = step_addr(src_q, pri_q.source_step_select, eff_width, gstep,
                              xfer.last_in_frame);
  assign dst_next = step_addr(dst_q, pri_q.dest_step_select, eff_width, gstep,
                              xfer.last_in_frame);

  // source and destination update per performed transfer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      src_q <= `DSAG_RST_WORD;
      dst_q <= `DSAG_RST_WORD;
    end else begin
      if (reg_wr && reg_addr == `DSAG_OFF_SRC)               src_q <= reg_wdata;
      else if (xfer_done && !xfer.is_write)                   src_q <= src_next;
      if (reg_wr && reg_addr == `DSAG_OFF_DST)               dst_q <= reg_wdata;
      else if (xfer_done && xfer.is_write)                    dst_q <= dst_next;
    end
  end

  assign src_addr = src_q;
  assign dst_addr = dst_q;
  assign access_width = eff_width;

  // byte lanes of the next access
  always_comb begin
    logic [1:0] a;
    a = pri_q.big_endian ? ~src_q[1:0] : src_q[1:0];
    if (xfer.is_write) a = pri_q.big_endian ? ~dst_q[1:0] : dst_q[1:0];
    case (eff_width)
      `DSAG_W_WORD: lane_en = 4'hf;
      `DSAG_W_HALF: lane_en = a[1] ? 4'hc : 4'h3;
      default:      lane_en = 4'h1 << a;
    endcase
  end

  // ============================================================
  // register read
  always_comb begin
    case (reg_addr)
      `DSAG_OFF_PRIMARY: rd_mux = pri_q;
      `DSAG_OFF_SECOND:  rd_mux = {29'h0, sec_q};
      `DSAG_OFF_STEP0:   rd_mux = step0_q;
      `DSAG_OFF_STEP1:   rd_mux = step1_q;
      `DSAG_OFF_SRC:     rd_mux = src_q;
      `DSAG_OFF_DST:     rd_mux = dst_q;
      `DSAG_OFF_STATUS:  rd_mux = {21'h0, wait_q, state_q, wr_active, rd_active};
      default:           rd_mux = 32'h0;                     // unmapped reads zero
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst)         reg_rdata <= 32'h0;
    else if (reg_rd) reg_rdata <= rd_mux;
    else             reg_rdata <= 32'h0;
  end
endmodule // dsag_channel

// ### dv/dsag_fifo_model.sv
/*
  flag model of an external fifo that raises the read sync event.
  assumes the bench sets the fill state and the flag polarity.
*/
`timescale 1ns/1ps
module dsag_fifo_model (
  input  wire logic core_clk, // core clock
  input  wire logic rst,      // sync reset, high
  input  wire logic fill,     // fifo holds a frame of data
  input  wire logic act_low,  // flag is active low
  output logic      pin       // flag driven onto the event pin
);
  // ============================================================
  // flag update, one clock late like a real fifo; a full fifo
  // keeps its flag active, so the channel can re-arm by level
  always_ff @(posedge core_clk) begin
    if (rst) pin <= act_low;
    else pin <= fill ^ act_low;
  end
endmodule // dsag_fifo_model

// ### dv/dsag_channel_checker.sv
/*
  port assertions of the channel: address steps, lanes, sync timing.
  assumes it is bound to dsag_channel; it shadows control writes.
*/
`timescale 1ns/1ps
`include "dsag_regs.svh"
module dsag_channel_checker import dsag_pkg::*; (
  input wire logic        core_clk,        // clock
  input wire logic        rst,             // reset
  input wire logic [7:0]  reg_addr,        // address
  input wire logic [31:0] reg_wdata,       // write data
  input wire logic        reg_wr,          // write strobe
  input wire logic        reg_rd,          // read strobe
  input wire logic [31:0] reg_rdata,       // read data
  input wire logic        read_event_pin,  // read event
  input wire logic        write_event_pin, // write event
  input wire logic        xfer_done,       // transfer done
  input wire dsag_xfer_t  xfer,            // transfer kind
  input wire logic        frame_done,      // burst end
  input wire logic        read_go,         // read allowed
  input wire logic        write_go,        // write allowed
  input wire logic [31:0] src_addr,        // source
  input wire logic [31:0] dst_addr,        // dest
  input wire logic [3:0]  lane_en,         // lanes
  input wire logic [1:0]  access_width     // width
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ============================================================
  // shadows of the control words and the post burst count
  dsag_primary_t pri_q; // primary control
  logic [2:0]    sec_q; // secondary control
  logic [5:0]    cnt_q; // cycles since burst end
  logic [31:0]   sz;    // element bytes
  assign sz = 32'h1 << pri_q.element_width;
  always_ff @(posedge core_clk) begin
    if (rst) pri_q <= '0;
    else if (reg_wr && reg_addr == `DSAG_OFF_PRIMARY) pri_q <= {13'h0, reg_wdata[18:0]};
  end
  always_ff @(posedge core_clk) begin
    if (rst) sec_q <= 3'h0;
    else if (reg_wr && reg_addr == `DSAG_OFF_SECOND) sec_q <= reg_wdata[2:0];
  end
  // counts 1..32 after a gated frame end
  always_ff @(posedge core_clk) begin
    if (rst) cnt_q <= 6'h00;
    else if (frame_done && pri_q.frame_sync && sec_q[2]) cnt_q <= 6'h01;
    else if (cnt_q != 6'h00 && cnt_q != 6'h20) cnt_q <= cnt_q + 6'h01;
    else cnt_q <= 6'h00;
  end
  // ============================================================
  // named steps
  sequence s_rd_step;
    xfer_done && !xfer.is_write && !xfer.prog_mem && !reg_wr;
  endsequence
  sequence s_wr_step;
    xfer_done && xfer.is_write && !xfer.prog_mem && !reg_wr;
  endsequence
  sequence s_wait_end;
    cnt_q == 6'h20 && (read_event_pin ^ sec_q[1]) && pri_q.read_event_select != 5'h00;
  endsequence
  // ============================================================
  // assertions
  a_src_step_up: assert property (
    s_rd_step ##0 pri_q.source_step_select == `DSAG_STEP_INC
    |=> src_addr == $past(src_addr) + $past(sz)) else $error("source step wrong");
  a_dst_step_down: assert property (
    s_wr_step ##0 pri_q.dest_step_select == `DSAG_STEP_DEC
    |=> dst_addr == $past(dst_addr) - $past(sz)) else $error("dest step wrong");
  a_src_keep: assert property (
    s_rd_step ##0 pri_q.source_step_select == `DSAG_STEP_KEEP |=> $stable(src_addr))
    else $error("source moved");
  a_prog_word: assert property (
    xfer.prog_mem |-> access_width == `DSAG_W_WORD) else $error("program access narrow");
  a_width_follow: assert property (
    !xfer.prog_mem |-> access_width == pri_q.element_width) else $error("width wrong");
  a_lane_little: assert property (
    pri_q.element_width == `DSAG_W_BYTE && !xfer.prog_mem && !xfer.is_write && !pri_q.big_endian
    |-> lane_en == 4'h1 << src_addr[1:0]) else $error("little lane wrong");
  a_lane_big: assert property (
    pri_q.element_width == `DSAG_W_BYTE && !xfer.prog_mem && !xfer.is_write && pri_q.big_endian
    |-> lane_en == 4'h8 >> src_addr[1:0]) else $error("big lane wrong");
  a_nosync_go: assert property (
    pri_q.read_event_select == `DSAG_SEL_NONE |-> read_go) else $error("unsynced read held");
  a_edge_latch: assert property (
    $rose(read_event_pin) && pri_q.read_event_select != 5'h00 && sec_q == 3'h0
    && !pri_q.frame_sync |-> ##[1:5] read_go) else $error("edge not latched");
  a_wait_quiet: assert property (
    cnt_q != 6'h00 && cnt_q != 6'h20 |-> !$rose(read_go)) else $error("latched in wait");
  a_level_rearm: assert property (
    s_wait_end |-> ##[0:6] read_go) else $error("no re-arm by level");
endmodule // dsag_channel_checker

bind dsag_channel dsag_channel_checker i_chk (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .read_event_pin(read_event_pin), .write_event_pin(write_event_pin),
  .xfer_done(xfer_done), .xfer(xfer), .frame_done(frame_done), .read_go(read_go),
  .write_go(write_go), .src_addr(src_addr), .dst_addr(dst_addr), .lane_en(lane_en),
  .access_width(access_width));

// ### dv/dsag_channel_tb.sv
/*
  testbench of the channel: register port, address steps, sync events.
  assumes the fifo model drives the read event pin; the bench drives the write pin.
*/
`timescale 1ns/1ps
`include "dsag_regs.svh"
module dsag_channel_tb import dsag_pkg::*; ;
  // ============================================================
  // signals
  logic        core_clk = 1'b0;  // 40 MHz clock
  logic        rst = 1'b1;       // sync reset
  logic [7:0]  reg_addr = 8'h00; // register address
  logic [31:0] reg_wdata = 32'h0, reg_rdata, src_addr, dst_addr, d, es, ed;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, xfer_done = 1'b0, frame_done = 1'b0;
  logic        fill = 1'b0, act_low = 1'b0, pin, read_go, write_go;
  logic        wpin = 1'b0;      // write event pin
  logic [3:0]  lane_en;          // byte lanes
  logic [1:0]  access_width;     // access width
  dsag_xfer_t  xfer = '0;        // transfer kind
  int          n_errors = 0, num_checks = 0, n, i;
  always #12.5 core_clk = ~core_clk;
  dsag_fifo_model i_fifo (.core_clk(core_clk), .rst(rst), .fill(fill), .act_low(act_low),
    .pin(pin));
  dsag_channel i_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .read_event_pin(pin), .write_event_pin(wpin), .xfer_done(xfer_done), .xfer(xfer),
    .frame_done(frame_done), .read_go(read_go), .write_go(write_go), .src_addr(src_addr),
    .dst_addr(dst_addr), .lane_en(lane_en), .access_width(access_width));
  // ============================================================
  // tasks: wr, rd, xf, fdone and flag start at a rising edge and end at a falling one
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask
  task automatic xf(input logic w, input logic last, input logic pm);
    @(posedge core_clk);
    xfer <= '{is_write: w, last_in_frame: last, prog_mem: pm};
    xfer_done <= 1'b1;
    @(posedge core_clk);
    xfer_done <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic fdone();
    @(posedge core_clk);
    frame_done <= 1'b1;
    @(posedge core_clk);
    frame_done <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic flag(input logic v);
    @(posedge core_clk);
    fill <= v;
    @(negedge core_clk);
  endtask
  // read_go must stay low for k cycles
  task automatic quiet(input int k);
    repeat (k) begin
      @(negedge core_clk);
      chk("read_go low", 32'h0, {31'h0, read_go});
    end
  endtask
  // bounded wait for read_go
  task automatic wait_go(input int lim);
    n = 0;
    while (read_go !== 1'b1) begin
      @(negedge core_clk);
      n++;
      if (n > lim) begin
        n_errors++;
        $display("BAD read_go exp 1 got %b", read_go);
        finish_test();
      end
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ============================================================
  // main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rd(`DSAG_OFF_PRIMARY, d);
    chk("primary", 32'h0, d);
    rd(`DSAG_OFF_SECOND, d);
    chk("secondary", 32'h0, d);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, d);
    chk("unmapped", 32'h0, d);
    chk("no sync go", 32'h1, {31'h0, read_go});
    $display("test reset done");
    es = 32'h100;
    ed = 32'h200;
    wr(`DSAG_OFF_SRC, es);
    wr(`DSAG_OFF_DST, ed);
    for (i = 2; i >= 0; i--) begin
      wr(`DSAG_OFF_PRIMARY, {26'h0, i[1:0], `DSAG_STEP_DEC, `DSAG_STEP_INC});
      xf(1'b0, 1'b0, 1'b0);
      xf(1'b1, 1'b0, 1'b0);
      es = es + (32'h1 << i);
      ed = ed - (32'h1 << i);
      chk("src step", es, src_addr);
      chk("dst step", ed, dst_addr);
    end
    wr(`DSAG_OFF_PRIMARY, 32'h0);
    xf(1'b0, 1'b0, 1'b0);
    xf(1'b1, 1'b0, 1'b0);
    chk("src keep", es, src_addr);
    chk("dst keep", ed, dst_addr);
    wr(`DSAG_OFF_STEP0, 32'hffee_0002);
    wr(`DSAG_OFF_STEP1, 32'h0000_fffc);
    wr(`DSAG_OFF_DST, 32'h300);
    wr(`DSAG_OFF_PRIMARY, {28'h0, `DSAG_STEP_IDX, `DSAG_STEP_KEEP});
    repeat (9) xf(1'b1, 1'b0, 1'b0);
    chk("dst element", 32'h312, dst_addr);
    xf(1'b1, 1'b1, 1'b0);
    chk("dst rewind", 32'h300, dst_addr);
    wr(`DSAG_OFF_PRIMARY, {24'h0, 1'b1, 3'h0, `DSAG_STEP_IDX, `DSAG_STEP_KEEP});
    xf(1'b1, 1'b0, 1'b0);
    chk("dst index 1", 32'h2fc, dst_addr);
    wr(`DSAG_OFF_SRC, 32'h100);
    wr(`DSAG_OFF_PRIMARY, 32'h0);
    xf(1'b0, 1'b0, 1'b0);
    chk("lane little", 32'h1, {28'h0, lane_en});
    chk("width byte", 32'h0, {30'h0, access_width});
    wr(`DSAG_OFF_PRIMARY, 32'h100);
    chk("lane big", 32'h8, {28'h0, lane_en});
    wr(`DSAG_OFF_SRC, 32'h103);
    chk("lane big 3", 32'h1, {28'h0, lane_en});
    xf(1'b0, 1'b0, 1'b1);
    chk("prog word", {30'h0, `DSAG_W_WORD}, {30'h0, access_width});
    $display("test address done");
    wr(`DSAG_OFF_PRIMARY, 32'h800);
    quiet(2);
    flag(1'b1);
    wait_go(10);
    xf(1'b0, 1'b0, 1'b0);
    quiet(12);
    flag(1'b0);
    wr(`DSAG_OFF_SECOND, 32'h2);
    @(posedge core_clk);
    act_low <= 1'b1;
    repeat (8) @(posedge core_clk);
    xf(1'b0, 1'b0, 1'b0);
    quiet(4);
    flag(1'b1);
    wait_go(10);
    xf(1'b0, 1'b0, 1'b0);
    flag(1'b0);
    wr(`DSAG_OFF_SECOND, 32'h6);
    wr(`DSAG_OFF_PRIMARY, 32'h840);
    quiet(4);
    flag(1'b1);
    wait_go(10);
    xf(1'b0, 1'b0, 1'b0);
    flag(1'b0);
    flag(1'b1);
    // burst reads proceed; the pin pulse must not latch behind them
    repeat (8) begin
      @(negedge core_clk);
      chk("burst go", 32'h1, {31'h0, read_go});
    end
    fdone();
    quiet(29);
    wait_go(12);
    xf(1'b0, 1'b0, 1'b0);
    flag(1'b0);
    fdone();
    quiet(45);
    $display("test sync done");
    // write sync: plain rising edge, then inverted by the write polarity
    wr(`DSAG_OFF_SECOND, 32'h0);
    wr(`DSAG_OFF_PRIMARY, 32'h4000);
    chk("write_go idle", 32'h0, {31'h0, write_go});
    @(posedge core_clk);
    wpin <= 1'b1;
    repeat (5) @(negedge core_clk);
    chk("write_go edge", 32'h1, {31'h0, write_go});
    xf(1'b1, 1'b0, 1'b0);
    chk("write_go clear", 32'h0, {31'h0, write_go});
    wr(`DSAG_OFF_SECOND, 32'h1);
    chk("write_go pol", 32'h0, {31'h0, write_go});
    @(posedge core_clk);
    wpin <= 1'b0;
    repeat (5) @(negedge core_clk);
    chk("write_go fall", 32'h1, {31'h0, write_go});
    $display("test write sync done");
    finish_test();
  end
endmodule // dsag_channel_tb
